// ==== inc/hp_pins_pkg.sv ====
// shared constants for the host port pin-function select pair
// assumes a single 250 MHz clock domain on both ends
package hp_pins_pkg;
   // shared pin group: index 0..3 = port bits nine..twelve
   localparam int NPIN = 4;
   localparam int IDX_B9 = 0;
   localparam int IDX_B10 = 1;
   localparam int IDX_B11 = 2;
   localparam int IDX_B12 = 3;
   // synchroniser depth for pins from outside the clock domain
   localparam int SYNC_DEPTH = 3;
   // per-pin general-purpose direction codes
   localparam logic [1:0] GPIO_DISC = 2'h0;
   localparam logic [1:0] GPIO_IN = 2'h1;
   localparam logic [1:0] GPIO_OUT = 2'h2;
   // polarity vector positions (1 = active high)
   localparam int POL_DS = 0;
   localparam int POL_RD = 1;
   localparam int POL_WR = 2;
   localparam int POL_AS = 3;
   // values after reset: function off, all strobes active low, pins idle
   localparam logic RST_HI_ACTIVE = 1'b0;
   localparam logic RST_MUX = 1'b0;
   localparam logic RST_DOUBLE = 1'b0;
   localparam logic [3:0] RST_POL = 4'h0;
   localparam logic [7:0] RST_GPIO_DIR = 8'h00;
   localparam logic [3:0] RST_GPIO_OUT = 4'h0;
   // controller register offsets (byte addresses)
   localparam logic [31:0] OFS_CFG = 32'h0000_0000;
   localparam logic [31:0] OFS_DRIVE = 32'h0000_0004;
   localparam logic [31:0] OFS_SENSE = 32'h0000_0008;
   // cfg register fields
   localparam int CFG_HI = 0;
   localparam int CFG_MUX = 1;
   localparam int CFG_DBL = 2;
   localparam int CFG_POL_LSB = 3;
   // drive register fields (logical, active high)
   localparam int DRV_A_LO = 0;
   localparam int DRV_A_HI = 1;
   localparam int DRV_RW = 2;
   localparam int DRV_DS = 3;
   localparam int DRV_RD = 4;
   localparam int DRV_WR = 5;
   localparam int DRV_AS = 6;
   localparam logic [6:0] RST_DRIVE = 7'h00;
   localparam logic [6:0] RST_CFG = 7'h00;
endpackage : hp_pins_pkg

// ==== inc/hp_pins_if.sv ====
// pin-level carrier between the device end and the host end
// the wire level of each shared pin is resolved here from the two enables
`timescale 1ns/10ps
`default_nettype none
interface hp_pins_if;
   // device drive of shared pins
   logic [3:0] dev_o;
   logic [3:0] dev_oe_n;
   // host drive of shared pins
   logic [3:0] host_o;
   logic [3:0] host_oe_n;
   // address strobe, host to device only
   logic as_o;
   // resolved wire level, pulled up when nobody drives
   logic [3:0] pin_lvl;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!dev_oe_n[i]) begin
            pin_lvl[i] = dev_o[i];
         end else if (!host_oe_n[i]) begin
            pin_lvl[i] = host_o[i];
         end else begin
            pin_lvl[i] = 1'b1;
         end
      end
   end
   modport device (output dev_o, output dev_oe_n, input pin_lvl, input as_o);
   modport host (output host_o, output host_oe_n, output as_o, input pin_lvl);
endinterface : hp_pins_if
`default_nettype wire

// ==== rtl/hp_dev_end.sv ====
// device end: decides the role of the shared host port pins and decodes them
// assumes the core loads the configuration through the cfg_* user ports and
// that every pin arrives asynchronously, so each passes a three-stage chain
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - pin roles follow the configured operating mode
// - nonmux: pin nine is address bit 1
// - nonmux: pin ten is address bit 2
// - mux: pin nine is address bit 8
// - mux: pin ten is address bit 9
// - host roles only when function selected
// - gpio bits: input, output or disconnected each
// - reset leaves all pins gpio disconnected
// - single strobe: pin eleven is read/write direction
// - single strobe: pin twelve is data strobe
// - double strobe: pin eleven is read strobe
// - double strobe: pin twelve is write strobe
// - strobe polarities programmable, active low after reset
// - address strobe polarity programmable, default low
module hp_dev_end
   import hp_pins_pkg::*;
(
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // pin side
   hp_pins_if.device pins,
   // configuration load from the core
   input wire logic cfg_load,
   input wire logic cfg_hi_active,
   input wire logic cfg_mux,
   input wire logic cfg_double,
   input wire logic [3:0] cfg_pol,
   input wire logic [7:0] cfg_gpio_dir,
   input wire logic [3:0] cfg_gpio_out,
   // decoded host access, all active high
   output logic [1:0] addr_lo,
   output logic [1:0] addr_hi,
   output logic host_rd_wr_dir,
   output logic rd_access,
   output logic wr_access,
   output logic addr_strobe_act,
   // general-purpose input values
   output logic [3:0] gpio_in
);

   // held configuration
   logic hi_active_r; // host interface function selected
   logic mux_r; // multiplexed bus style
   logic double_r; // two data strobes instead of one
   logic [3:0] pol_r; // strobe polarities, 1 = active high
   logic [7:0] gpio_dir_r; // two bits per pin
   logic [3:0] gpio_out_r; // output values in gpio mode

   // synchroniser chains: bits 0..3 shared pins, bit 4 address strobe
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [4:0] sync3_r;
   logic [4:0] filt_r; // accepted level once stages two and three agree
   logic [4:0] raw_in; // pin levels gathered for the chain

   // pin drive registers
   logic [3:0] dev_o_r;
   logic [3:0] dev_oe_n_r;

   // active-high qualifiers after the polarity stage
   logic ds_act;
   logic rd_act;
   logic wr_act;
   logic as_act;

   assign raw_in = {pins.as_o, pins.pin_lvl};

   // configuration register; reset puts the pins in gpio disconnected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_active_r <= RST_HI_ACTIVE;
         mux_r <= RST_MUX;
         double_r <= RST_DOUBLE;
         pol_r <= RST_POL;
         gpio_dir_r <= RST_GPIO_DIR;
         gpio_out_r <= RST_GPIO_OUT;
      end else if (clk_en && cfg_load) begin
         hi_active_r <= cfg_hi_active;
         mux_r <= cfg_mux;
         double_r <= cfg_double;
         pol_r <= cfg_pol;
         gpio_dir_r <= cfg_gpio_dir;
         gpio_out_r <= cfg_gpio_out;
      end
   end

   // three-stage chain per pin; stage one feeds stage two only.
   // the agreement filter also stands in for the schmitt input on strobes,
   // at the cost of one extra cycle of latency on every pin
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync1_r[g] <= 1'b1;
               sync2_r[g] <= 1'b1;
               sync3_r[g] <= 1'b1;
               filt_r[g] <= 1'b1;
            end else if (clk_en) begin
               sync1_r[g] <= raw_in[g];
               sync2_r[g] <= sync1_r[g];
               sync3_r[g] <= sync2_r[g];
               // only a level seen twice in a row is accepted
               if (sync2_r[g] == sync3_r[g]) begin
                  filt_r[g] <= sync3_r[g];
               end
            end
         end
      end
   endgenerate

   // gpio drive and sampling per pin
   generate
      for (g = 0; g < NPIN; g++) begin : g_gpio
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               dev_o_r[g] <= 1'b0;
               dev_oe_n_r[g] <= 1'b1;
               gpio_in[g] <= 1'b0;
            end else if (clk_en) begin
               if (hi_active_r) begin
                  // host roles: the device only listens
                  dev_o_r[g] <= 1'b0;
                  dev_oe_n_r[g] <= 1'b1;
                  gpio_in[g] <= 1'b0;
               end else begin
                  // each bit follows its own direction code
                  dev_o_r[g] <= gpio_out_r[g];
                  dev_oe_n_r[g] <= (gpio_dir_r[2*g +: 2] != GPIO_OUT);
                  // a disconnected pin is not sampled and reads zero
                  gpio_in[g] <= (gpio_dir_r[2*g +: 2] == GPIO_IN) ? filt_r[g] : 1'b0;
               end
            end
         end
      end
   endgenerate

   assign pins.dev_o = dev_o_r;
   assign pins.dev_oe_n = dev_oe_n_r;

   // polarity stage: xor with the inverse of the active-high flag
   always_comb begin
      ds_act = filt_r[IDX_B12] ^ ~pol_r[POL_DS];
      rd_act = filt_r[IDX_B11] ^ ~pol_r[POL_RD];
      wr_act = filt_r[IDX_B12] ^ ~pol_r[POL_WR];
      as_act = filt_r[4] ^ ~pol_r[POL_AS];
   end

   // address decode: the same two pins carry low or high address bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_lo <= 2'h0;
         addr_hi <= 2'h0;
      end else if (clk_en) begin
         if (hi_active_r && !mux_r) begin
            addr_lo[0] <= filt_r[IDX_B9];
            addr_lo[1] <= filt_r[IDX_B10];
            addr_hi <= 2'h0;
         end else if (hi_active_r && mux_r) begin
            addr_hi[0] <= filt_r[IDX_B9];
            addr_hi[1] <= filt_r[IDX_B10];
            addr_lo <= 2'h0;
         end else begin
            // gpio mode: no address role at all
            addr_lo <= 2'h0;
            addr_hi <= 2'h0;
         end
      end
   end

   // strobe decode into read and write qualifiers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_rd_wr_dir <= 1'b0;
         rd_access <= 1'b0;
         wr_access <= 1'b0;
      end else if (clk_en) begin
         if (!hi_active_r) begin
            host_rd_wr_dir <= 1'b0;
            rd_access <= 1'b0;
            wr_access <= 1'b0;
         end else if (!double_r) begin
            // single strobe: pin eleven high means read
            host_rd_wr_dir <= filt_r[IDX_B11];
            rd_access <= ds_act && filt_r[IDX_B11];
            wr_access <= ds_act && !filt_r[IDX_B11];
         end else begin
            // double strobe: each pin qualifies one direction
            host_rd_wr_dir <= rd_act;
            rd_access <= rd_act;
            wr_access <= wr_act;
         end
      end
   end

   // address strobe only has meaning on a multiplexed bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_strobe_act <= 1'b0;
      end else if (clk_en) begin
         addr_strobe_act <= hi_active_r && mux_r && as_act;
      end
   end

endmodule : hp_dev_end
`default_nettype wire

// ==== rtl/hp_host_end.sv ====
// host end: an AHB-Lite slave whose registers steer the host side of the pins
// assumes a single AHB-Lite master, word transfers only, on the same clock
`timescale 1ns/10ps
`default_nettype none
module hp_host_end
   import hp_pins_pkg::*;
(
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pin side
   hp_pins_if.host pins
);

   logic [6:0] cfg_r; // function, style and polarity bits
   logic [6:0] drive_r; // logical levels to present, active high
   logic wr_pend_r; // write data phase pending
   logic [31:0] wr_addr_r; // address of that write
   logic [3:0] s1_r; // pin sampling chain
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   logic [3:0] sense_r; // accepted pin levels
   logic [3:0] host_o_r;
   logic [3:0] host_oe_n_r;
   logic as_o_r;
   logic addr_ph; // valid address phase this cycle
   logic [3:0] pol; // polarity vector from cfg

   assign addr_ph = hsel && hready && htrans[1];
   assign pol = cfg_r[CFG_POL_LSB +: 4];

   // bus phases; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         cfg_r <= RST_CFG;
         drive_r <= RST_DRIVE;
      end else if (clk_en) begin
         wr_pend_r <= addr_ph && hwrite;
         wr_addr_r <= haddr;
         // read data is set up for the coming data phase
         if (addr_ph && !hwrite) begin
            unique case (haddr)
               OFS_CFG: hrdata <= {25'h0, cfg_r};
               OFS_DRIVE: hrdata <= {25'h0, drive_r};
               OFS_SENSE: hrdata <= {28'h0, sense_r};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
         if (wr_pend_r) begin
            if (wr_addr_r == OFS_CFG) begin
               cfg_r <= hwdata[6:0];
            end else if (wr_addr_r == OFS_DRIVE) begin
               drive_r <= hwdata[6:0];
            end
         end
      end
   end

   // pin sampling, three stages with agreement
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= 4'hf;
         s2_r <= 4'hf;
         s3_r <= 4'hf;
         sense_r <= 4'hf;
      end else if (clk_en) begin
         s1_r <= pins.pin_lvl;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < 4; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               sense_r[i] <= s3_r[i];
            end
         end
      end
   end

   // pin drive: shared pins released unless the function is on; the address strobe is always driven
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_o_r <= 4'hf;
         host_oe_n_r <= 4'hf;
         as_o_r <= 1'b1;
      end else if (clk_en) begin
         host_oe_n_r <= {4{~cfg_r[CFG_HI]}};
         host_o_r[IDX_B9] <= drive_r[DRV_A_LO];
         host_o_r[IDX_B10] <= drive_r[DRV_A_HI];
         as_o_r <= drive_r[DRV_AS] ^ ~pol[POL_AS];
         if (!cfg_r[CFG_DBL]) begin
            host_o_r[IDX_B11] <= drive_r[DRV_RW];
            host_o_r[IDX_B12] <= drive_r[DRV_DS] ^ ~pol[POL_DS];
         end else begin
            host_o_r[IDX_B11] <= drive_r[DRV_RD] ^ ~pol[POL_RD];
            host_o_r[IDX_B12] <= drive_r[DRV_WR] ^ ~pol[POL_WR];
         end
      end
   end

   assign pins.host_o = host_o_r;
   assign pins.host_oe_n = host_oe_n_r;
   assign pins.as_o = as_o_r;

endmodule : hp_host_end
`default_nettype wire

// ==== bench/hp_pins_props.sv ====
// checker for the pin pair: wire levels and device decode against the loaded mode
// assumes one clock and that the device config changes only through cfg_load
`timescale 1ns/10ps
`default_nettype none
module hp_pins_props
   import hp_pins_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // configuration load
   input wire logic cfg_load,
   input wire logic cfg_hi_active,
   input wire logic cfg_mux,
   input wire logic cfg_double,
   input wire logic [3:0] cfg_pol,
   input wire logic [7:0] cfg_gpio_dir,
   input wire logic [3:0] cfg_gpio_out,
   // wire side
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe_n,
   input wire logic as_o,
   input wire logic [3:0] pin_lvl,
   // decode side
   input wire logic [1:0] addr_lo,
   input wire logic [1:0] addr_hi,
   input wire logic host_rd_wr_dir,
   input wire logic rd_access,
   input wire logic wr_access,
   input wire logic addr_strobe_act,
   input wire logic [3:0] gpio_in
);
   logic hi_r, mux_r, dbl_r, seen_r; // shadow mode, load seen since reset
   logic [3:0] pol_r, out_r, age_r, oe_exp, in_m; // age saturates at 15
   logic [7:0] dir_r;
   logic settled, ds, rd, wr; // logical strobes, active high
   // shadow the config; the decode pipe needs a few edges after a load
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {hi_r, mux_r, dbl_r, seen_r} <= {RST_HI_ACTIVE, RST_MUX, RST_DOUBLE, 1'b0};
         pol_r <= RST_POL;
         dir_r <= RST_GPIO_DIR;
         out_r <= RST_GPIO_OUT;
         age_r <= 4'h0;
      end else if (cfg_load) begin
         {hi_r, mux_r, dbl_r, seen_r} <= {cfg_hi_active, cfg_mux, cfg_double, 1'b1};
         pol_r <= cfg_pol;
         dir_r <= cfg_gpio_dir;
         out_r <= cfg_gpio_out;
         age_r <= 4'h0;
      end else if (age_r != 4'hf) begin
         age_r <= age_r + 4'h1;
      end
   end
   // expected enables and gpio input mask per pin
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         oe_exp[i] = hi_r || (dir_r[2*i +: 2] != GPIO_OUT);
         in_m[i] = !hi_r && (dir_r[2*i +: 2] == GPIO_IN);
      end
   end
   assign settled = (age_r >= 4'h8);
   assign ds = pin_lvl[IDX_B12] ^ ~pol_r[POL_DS];
   assign rd = pin_lvl[IDX_B11] ^ ~pol_r[POL_RD];
   assign wr = pin_lvl[IDX_B12] ^ ~pol_r[POL_WR];
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // pins held long enough to cross the sync chain and filter
   sequence pins_held;
      ($stable(pin_lvl) && $stable(as_o))[*6];
   endsequence
   sequence host_mode;
      pins_held ##0 (settled && hi_r);
   endsequence
   reset_idle_a: assert property (!seen_r |-> dev_oe_n == 4'hf && gpio_in == 4'h0
      && {addr_lo, addr_hi, rd_access, wr_access} == 6'h0) else $error("pins not idle after reset");
   gpio_drive_a: assert property (settled |-> dev_oe_n == oe_exp
      && (dev_o | dev_oe_n) == (out_r | dev_oe_n)) else $error("device pin drive wrong");
   gpio_quiet_a: assert property (settled && !hi_r |-> !(rd_access || wr_access || addr_strobe_act)
      && !host_rd_wr_dir && addr_lo == 2'h0 && addr_hi == 2'h0) else $error("host decode in gpio mode");
   gpio_sense_a: assert property (pins_held ##0 settled |-> gpio_in == (pin_lvl & in_m))
      else $error("gpio input sample wrong");
   nonmux_addr_a: assert property (host_mode ##0 !mux_r |-> addr_lo == pin_lvl[1:0])
      else $error("nonmux address wrong");
   mux_addr_a: assert property (host_mode ##0 mux_r |-> addr_hi == pin_lvl[1:0]
      && addr_strobe_act == (as_o ^ ~pol_r[POL_AS])) else $error("mux address or strobe wrong");
   single_strobe_a: assert property (host_mode ##0 !dbl_r |-> host_rd_wr_dir == pin_lvl[IDX_B11]
      && rd_access == (ds && pin_lvl[IDX_B11]) && wr_access == (ds && !pin_lvl[IDX_B11]))
      else $error("single strobe decode wrong");
   double_strobe_a: assert property (host_mode ##0 dbl_r |-> rd_access == rd && wr_access == wr
      && host_rd_wr_dir == rd) else $error("double strobe decode wrong");
endmodule : hp_pins_props
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench: host end on AHB-Lite facing the device end over the pins
// assumes both ends share hclk; expected values kept in one queue
`timescale 1ns/10ps
`default_nettype none
module testbench
   import hp_pins_pkg::*;
;
   logic hclk, hresetn, cfg_load, cfg_hi_active, cfg_mux, cfg_double, hwrite, hreadyout, hresp;
   logic host_rd_wr_dir, rd_access, wr_access, addr_strobe_act, snap, dbl, mux;
   logic rd_dp = 1'b0; // read data phase seen by the watcher, owned by it alone
   logic [1:0] addr_lo, addr_hi, htrans;
   logic [3:0] cfg_pol, cfg_gpio_out, gpio_in, lvl, gin, pol, out;
   logic [7:0] cfg_gpio_dir, dir;
   logic [6:0] drv; // logical host drive bits
   logic [2:0] m; // {double, mux, function on}
   logic [31:0] haddr, hwdata, hrdata, got;
   logic [15:0] obs;
   logic [63:0] ent, q[$]; // {mask, expected}
   // counters start at their declaration so that only the watcher writes them
   int failures = 0, num_checks = 0, cycles = 0, seed = 89936, k;
   hp_pins_if pins_if();
   assign obs = {pins_if.pin_lvl, gpio_in, addr_strobe_act, wr_access, rd_access, host_rd_wr_dir, addr_hi, addr_lo};
   hp_dev_end hp_dev_end_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .pins(pins_if), .cfg_load(cfg_load),
      .cfg_hi_active(cfg_hi_active), .cfg_mux(cfg_mux), .cfg_double(cfg_double), .cfg_pol(cfg_pol),
      .cfg_gpio_dir(cfg_gpio_dir), .cfg_gpio_out(cfg_gpio_out), .addr_lo(addr_lo), .addr_hi(addr_hi),
      .host_rd_wr_dir(host_rd_wr_dir), .rd_access(rd_access), .wr_access(wr_access),
      .addr_strobe_act(addr_strobe_act), .gpio_in(gpio_in));
   hp_host_end hp_host_end_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pins(pins_if));
   hp_pins_props hp_pins_props_i (.hclk(hclk), .hresetn(hresetn), .cfg_load(cfg_load),
      .cfg_hi_active(cfg_hi_active), .cfg_mux(cfg_mux), .cfg_double(cfg_double), .cfg_pol(cfg_pol),
      .cfg_gpio_dir(cfg_gpio_dir), .cfg_gpio_out(cfg_gpio_out), .dev_o(pins_if.dev_o),
      .dev_oe_n(pins_if.dev_oe_n), .as_o(pins_if.as_o), .pin_lvl(pins_if.pin_lvl), .addr_lo(addr_lo),
      .addr_hi(addr_hi), .host_rd_wr_dir(host_rd_wr_dir), .rd_access(rd_access), .wr_access(wr_access),
      .addr_strobe_act(addr_strobe_act), .gpio_in(gpio_in));
   // free-running clock, 4 ns period
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // single AHB transfer; waits on hready in both phases, no fixed latency assumed
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : ahb
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      q.push_back({32'hffff_ffff, e});
      ahb(1'b0, a, 32'h0);
   endtask : rd
   // let pins cross the sync chain, then snapshot the decode outputs
   task automatic dev_chk(input logic [15:0] mk, input logic [15:0] e);
      repeat (8) @(posedge hclk);
      q.push_back({16'h0, mk, 16'h0, e});
      snap <= 1'b1;
      @(posedge hclk);
      snap <= 1'b0;
   endtask : dev_chk
   task automatic both_cfg(input logic [7:0] d, input logic [3:0] o);
      ahb(1'b1, OFS_CFG, {25'h0, pol, m});
      ahb(1'b1, OFS_DRIVE, {25'h0, drv});
      @(posedge hclk);
      {cfg_double, cfg_mux, cfg_hi_active} <= m;
      cfg_pol <= pol;
      cfg_gpio_dir <= d;
      cfg_gpio_out <= o;
      cfg_load <= 1'b1;
      @(posedge hclk);
      cfg_load <= 1'b0;
   endtask : both_cfg
   // watcher: takes the oldest note whenever a read or snapshot lands
   always @(posedge hclk) begin
      if ((rd_dp || snap) && q.size() > 0) begin
         ent = q.pop_front();
         got = (rd_dp ? hrdata : {16'h0, obs}) & ent[63:32];
         num_checks++;
         if (got !== ent[31:0]) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, ent[31:0]);
         end
         // the slave must answer every read data phase with OKAY
         if (rd_dp && hresp !== 1'b0) begin
            failures++;
            $display("[ERR] t=%0t hresp %h exp %h", $time, hresp, 1'b0);
         end
      end
      rd_dp <= htrans[1] && !hwrite && hreadyout;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      {hresetn, cfg_load, cfg_hi_active, cfg_mux, cfg_double, hwrite, snap} = 7'h0;
      {cfg_pol, cfg_gpio_out, cfg_gpio_dir, htrans, haddr, hwdata} = 82'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // idle after reset: pulled-up pins, defaults in registers, unmapped place reads zero
      dev_chk(16'hffff, 16'hf000);
      rd(OFS_CFG, 32'h0);
      rd(OFS_DRIVE, 32'h0);
      ahb(1'b1, 32'h0000_000c, $random(seed));
      rd(32'h0000_000c, 32'h0);
      // gpio mode: random direction per pin, host driving on odd passes
      for (k = 0; k < 6; k++) begin
         drv = 7'($random(seed));
         out = 4'($random(seed));
         pol = 4'hf;
         m = {2'b00, k[0]};
         for (int i = 0; i < 4; i++) begin
            dir[2*i +: 2] = 2'(($random(seed) & 32'h7fff_ffff) % 3);
            lvl[i] = (dir[2*i +: 2] == GPIO_OUT) ? out[i] : (k[0] ? drv[i] : 1'b1);
            gin[i] = (dir[2*i +: 2] == GPIO_IN) && lvl[i];
         end
         ahb(1'b1, OFS_CFG, {25'h0, pol, m});
         ahb(1'b1, OFS_DRIVE, {25'h0, drv});
         @(posedge hclk);
         {cfg_double, cfg_mux, cfg_hi_active} <= 3'b000;
         cfg_pol <= 4'($random(seed));
         cfg_gpio_dir <= dir;
         cfg_gpio_out <= out;
         cfg_load <= 1'b1;
         @(posedge hclk);
         cfg_load <= 1'b0;
         dev_chk(16'hffff, {lvl, gin, 8'h0});
         rd(OFS_SENSE, {28'h0, lvl});
      end
      // host function: every bus style twice, polarity defaults first then random
      for (k = 0; k < 8; k++) begin
         {dbl, mux} = k[1:0];
         m = {dbl, mux, 1'b1};
         pol = (k < 4) ? RST_POL : 4'($random(seed));
         drv = 7'($random(seed));
         lvl = {dbl ? drv[5] ^ ~pol[2] : drv[3] ^ ~pol[0], dbl ? drv[4] ^ ~pol[1] : drv[2], drv[1:0]};
         both_cfg(8'($random(seed)), 4'($random(seed)));
         // the unused address group and the address strobe must read zero in the other bus style
         dev_chk(16'hffff, {lvl, 4'h0, mux & drv[6],
            dbl ? drv[5] : drv[3] & ~drv[2], dbl ? drv[4] : drv[3] & drv[2], dbl ? drv[4] : drv[2],
            mux ? drv[1:0] : 2'h0, mux ? 2'h0 : drv[1:0]});
         rd(OFS_CFG, {25'h0, pol, m});
      end
      // reset in mid-run returns everything to gpio disconnected
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      dev_chk(16'hffff, 16'hf000);
      rd(OFS_CFG, 32'h0);
      repeat (4) @(posedge hclk);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
